// ===== hw/ast_pkg.sv
// constants and register map of the asynchronous serial transceiver
package ast_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] AST_OFS_CONTROL = 8'h00;
    localparam logic [7:0] AST_OFS_STATUS = 8'h04;
    localparam logic [7:0] AST_OFS_DATA_HIGH = 8'h08;
    localparam logic [7:0] AST_OFS_DATA_LOW = 8'h0C;
    localparam logic [7:0] AST_OFS_DIVISOR = 8'h10;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int AST_CTL_NINE_BIT = 4;
    localparam int AST_DH_RX_NINTH = 7;
    localparam int AST_DH_TX_NINTH = 6;
    localparam int AST_ST_TX_READY = 7;
    localparam int AST_ST_TX_IDLE = 6;
    localparam int AST_ST_RX_FULL = 5;
    localparam int AST_ST_OVERRUN = 3;
    localparam int AST_ST_NOISE = 2;
    localparam int AST_ST_FRAMING = 1;
    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam int AST_DIV_W = 13;
    localparam logic [12:0] AST_DIV_RESET = 13'h0004;
    localparam logic [3:0] AST_TICKS_LAST = 4'hF;
    localparam logic [3:0] AST_TICK_A = 4'h7;
    localparam logic [3:0] AST_TICK_B = 4'h8;
    localparam logic [3:0] AST_TICK_C = 4'h9;
    localparam logic [3:0] AST_TICK_START_CHECK = 4'h3;
    localparam int AST_FIFO_DEPTH = 16;
    localparam logic [1:0] AST_RESP_OKAY = 2'h0;
    localparam logic [1:0] AST_RESP_SLVERR = 2'h2;
endpackage : ast_pkg

// ===== hw/ast_fifo.sv
// synchronous valid/ready fifo built from flip-flops
`timescale 1ns/10ps
`default_nettype none
module ast_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // handshake terms with honest full and empty
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage write
    always_ff @(posedge aclk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : ast_fifo
`default_nettype wire

// ===== hw/ast_top.sv
// asynchronous serial transceiver with axi4-lite register slave
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module ast_top #(
    parameter int FIFO_DEPTH = ast_pkg::AST_FIFO_DEPTH
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial line
    input wire logic rx_pin,
    output logic tx_pin
);
    import ast_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic nine_bit_reg;
    logic [AST_DIV_W-1:0] divisor_reg;
    logic tx_ninth_bit_reg;
    logic rx_ninth_bit_reg;
    logic [7:0] rx_data_reg;
    logic rx_full_flag_reg;
    logic noise_flag_reg;
    logic framing_flag_reg;
    logic overrun_flag_reg;
    logic status_seen_reg;
    logic aw_held_reg;
    logic [7:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    logic wr_fire;
    logic wr_low_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [8:0] fifo_out_data;

    // a data-low write waits while the fifo is full, so back-pressure reaches the master
    assign wr_low_data = (aw_addr_reg == AST_OFS_DATA_LOW) && w_strb_reg[0];
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid
        && (!wr_low_data || fifo_in_ready);

    // address and data accepted in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AST_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_reg)
                    AST_OFS_CONTROL, AST_OFS_STATUS, AST_OFS_DATA_HIGH,
                    AST_OFS_DATA_LOW, AST_OFS_DIVISOR: s_axi_bresp <= AST_RESP_OKAY;
                    default: s_axi_bresp <= AST_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // writable configuration fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nine_bit_reg <= 1'b0;
            divisor_reg <= AST_DIV_RESET;
            tx_ninth_bit_reg <= 1'b0;
        end else if (wr_fire) begin
            if (aw_addr_reg == AST_OFS_CONTROL && w_strb_reg[0]) begin
                nine_bit_reg <= w_data_reg[AST_CTL_NINE_BIT];
            end
            if (aw_addr_reg == AST_OFS_DATA_HIGH && w_strb_reg[0]) begin
                tx_ninth_bit_reg <= w_data_reg[AST_DH_TX_NINTH];
            end
            if (aw_addr_reg == AST_OFS_DIVISOR) begin
                if (w_strb_reg[0]) begin
                    divisor_reg[7:0] <= w_data_reg[7:0];
                end
                if (w_strb_reg[1]) begin
                    divisor_reg[12:8] <= w_data_reg[12:8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // transmit buffer: low write pushes ninth bit plus byte
    // ------------------------------------------------------------
    ast_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(wr_fire && wr_low_data),
        .in_ready(fifo_in_ready),
        .in_data({tx_ninth_bit_reg, w_data_reg[7:0]}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------
    // baud tick: sixteen ticks per bit
    // ------------------------------------------------------------
    logic [AST_DIV_W-1:0] baud_cnt_reg;
    logic tick_reg;

    // divisor of zero holds the ticks off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            baud_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (divisor_reg == '0) begin
            baud_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (baud_cnt_reg >= divisor_reg - 1'b1) begin
            baud_cnt_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            baud_cnt_reg <= baud_cnt_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    logic [10:0] tx_shift_reg;
    logic [3:0] tx_bits_reg;
    logic [3:0] tx_sub_reg;
    logic tx_busy_reg;

    assign fifo_out_ready = !tx_busy_reg;

    // shift stop, data and start out lsb first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_shift_reg <= '1;
            tx_bits_reg <= 4'h0;
            tx_sub_reg <= 4'h0;
            tx_busy_reg <= 1'b0;
            tx_pin <= 1'b1;
        end else if (!tx_busy_reg) begin
            tx_pin <= 1'b1;
            if (fifo_out_valid) begin
                tx_busy_reg <= 1'b1;
                tx_sub_reg <= 4'h0;
                if (nine_bit_reg) begin
                    tx_shift_reg <= {1'b1, fifo_out_data, 1'b0};
                    tx_bits_reg <= 4'hB;
                end else begin
                    tx_shift_reg <= {2'b11, fifo_out_data[7:0], 1'b0};
                    tx_bits_reg <= 4'hA;
                end
            end
        end else begin
            tx_pin <= tx_shift_reg[0];
            if (tick_reg) begin
                tx_sub_reg <= tx_sub_reg + 1'b1;
                if (tx_sub_reg == AST_TICKS_LAST) begin
                    tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                    tx_bits_reg <= tx_bits_reg - 1'b1;
                    if (tx_bits_reg == 4'h1) begin
                        tx_busy_reg <= 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // receive pin synchroniser: three stages, second and third agree
    // ------------------------------------------------------------
    logic [2:0] rx_sync_reg;
    logic rx_level_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_sync_reg <= 3'b111;
            rx_level_reg <= 1'b1;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], rx_pin};
            if (rx_sync_reg[1] == rx_sync_reg[2]) begin
                rx_level_reg <= rx_sync_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // receiver state machine
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        AST_RX_IDLE = 4'b0001,
        AST_RX_START = 4'b0010,
        AST_RX_DATA = 4'b0100,
        AST_RX_STOP = 4'b1000
    } ast_rx_state_type;

    ast_rx_state_type rx_state_reg;
    logic [3:0] rx_sub_reg;
    logic [3:0] rx_bit_reg;
    logic [2:0] rx_samp_reg;
    logic [8:0] rx_shift_reg;
    logic rx_noise_reg;
    logic rx_done;
    logic rx_frame_err;
    logic majority;
    logic disagree;

    // majority and disagreement of the three mid-bit samples
    assign majority = (rx_samp_reg[2] & rx_samp_reg[1]) | (rx_samp_reg[2] & rx_samp_reg[0])
        | (rx_samp_reg[1] & rx_samp_reg[0]);
    assign disagree = (rx_samp_reg != 3'b000) && (rx_samp_reg != 3'b111);
    assign rx_done = tick_reg && (rx_state_reg == AST_RX_STOP)
        && (rx_sub_reg == AST_TICKS_LAST);
    assign rx_frame_err = !majority;

    // sample ticks and bit assembly
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_state_reg <= AST_RX_IDLE;
            rx_sub_reg <= 4'h0;
            rx_bit_reg <= 4'h0;
            rx_samp_reg <= 3'b000;
            rx_shift_reg <= '0;
            rx_noise_reg <= 1'b0;
        end else if (tick_reg) begin
            rx_sub_reg <= rx_sub_reg + 1'b1;
            if (rx_sub_reg == AST_TICK_A || rx_sub_reg == AST_TICK_B
                    || rx_sub_reg == AST_TICK_C) begin
                rx_samp_reg <= {rx_samp_reg[1:0], rx_level_reg};
            end
            case (rx_state_reg)
                AST_RX_IDLE: begin
                    rx_sub_reg <= 4'h0;
                    if (!rx_level_reg) begin
                        rx_state_reg <= AST_RX_START;
                        rx_noise_reg <= 1'b0;
                    end
                end
                AST_RX_START: begin
                    // early check rejects a glitch before the start is verified
                    if (rx_sub_reg == AST_TICK_START_CHECK && rx_level_reg) begin
                        rx_state_reg <= AST_RX_IDLE;
                    end else if (rx_sub_reg == AST_TICKS_LAST) begin
                        rx_noise_reg <= rx_samp_reg != 3'b000;
                        rx_state_reg <= AST_RX_DATA;
                        rx_bit_reg <= 4'h0;
                    end
                end
                AST_RX_DATA: begin
                    if (rx_sub_reg == AST_TICKS_LAST) begin
                        rx_shift_reg <= {majority, rx_shift_reg[8:1]};
                        rx_noise_reg <= rx_noise_reg | disagree;
                        rx_bit_reg <= rx_bit_reg + 1'b1;
                        if (rx_bit_reg == (nine_bit_reg ? 4'h8 : 4'h7)) begin
                            rx_state_reg <= AST_RX_STOP;
                        end
                    end
                end
                AST_RX_STOP: begin
                    if (rx_sub_reg == AST_TICKS_LAST) begin
                        rx_state_reg <= AST_RX_IDLE;
                    end
                end
                default: rx_state_reg <= AST_RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path and receive flags
    // ------------------------------------------------------------
    logic rd_take;
    logic rd_data_clear;

    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_data_clear = rd_take && ({s_axi_araddr[7:2], 2'b00} == AST_OFS_DATA_LOW)
        && status_seen_reg;

    // frame completion wins over a clearing read in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_data_reg <= 8'h00;
            rx_ninth_bit_reg <= 1'b0;
            rx_full_flag_reg <= 1'b0;
            noise_flag_reg <= 1'b0;
            framing_flag_reg <= 1'b0;
            overrun_flag_reg <= 1'b0;
            status_seen_reg <= 1'b0;
        end else if (rx_done) begin
            if (rx_full_flag_reg && !rd_data_clear) begin
                overrun_flag_reg <= 1'b1;
            end else begin
                rx_data_reg <= nine_bit_reg ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
                rx_ninth_bit_reg <= nine_bit_reg & rx_shift_reg[8];
                rx_full_flag_reg <= 1'b1;
                noise_flag_reg <= rx_noise_reg | disagree;
                framing_flag_reg <= rx_frame_err;
                overrun_flag_reg <= 1'b0;
            end
            status_seen_reg <= 1'b0;
        end else if (rd_take) begin
            if ({s_axi_araddr[7:2], 2'b00} == AST_OFS_STATUS) begin
                status_seen_reg <= rx_full_flag_reg;
            end else if (rd_data_clear) begin
                rx_full_flag_reg <= 1'b0;
                noise_flag_reg <= 1'b0;
                framing_flag_reg <= 1'b0;
                overrun_flag_reg <= 1'b0;
                status_seen_reg <= 1'b0;
            end
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AST_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= AST_RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                case ({s_axi_araddr[7:2], 2'b00})
                    AST_OFS_CONTROL: s_axi_rdata[AST_CTL_NINE_BIT] <= nine_bit_reg;
                    AST_OFS_STATUS: begin
                        s_axi_rdata[AST_ST_TX_READY] <= fifo_in_ready;
                        s_axi_rdata[AST_ST_TX_IDLE] <= !tx_busy_reg && !fifo_out_valid;
                        s_axi_rdata[AST_ST_RX_FULL] <= rx_full_flag_reg;
                        s_axi_rdata[AST_ST_OVERRUN] <= overrun_flag_reg;
                        s_axi_rdata[AST_ST_NOISE] <= noise_flag_reg;
                        s_axi_rdata[AST_ST_FRAMING] <= framing_flag_reg;
                    end
                    AST_OFS_DATA_HIGH: s_axi_rdata[AST_DH_RX_NINTH] <= rx_ninth_bit_reg;
                    AST_OFS_DATA_LOW: s_axi_rdata[7:0] <= rx_data_reg;
                    AST_OFS_DIVISOR: s_axi_rdata[AST_DIV_W-1:0] <= divisor_reg;
                    default: s_axi_rresp <= AST_RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : ast_top
`default_nettype wire

// ===== dv/ast_monitor.sv
// assertion checker on the transceiver top ports
`timescale 1ns/10ps
`default_nettype none
module ast_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial line
    input wire logic tx_pin
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // answers stand until taken, then drop
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    // read data one cycle after the address is taken
    property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    // a taken write is answered in bounded time, even behind a full fifo
    property p_w_resp; s_axi_awvalid && s_axi_awready |-> ##[1:1000] s_axi_bvalid; endproperty
    // start bit and every bit last at least nine clocks
    property p_start; $fell(tx_pin) |=> !tx_pin [*8]; endproperty
    property p_bit_min; $changed(tx_pin) |=> $stable(tx_pin) [*8]; endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
    a_b_done: assert property (p_b_done) else $error("bvalid stuck");
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    a_r_done: assert property (p_r_done) else $error("rvalid stuck");
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    a_w_resp: assert property (p_w_resp) else $error("write answer missing");
    a_start: assert property (p_start) else $error("start bit short");
    a_bit_min: assert property (p_bit_min) else $error("bit time short");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
    c_tx: cover property ($fell(tx_pin));
endmodule : ast_monitor
bind ast_top ast_monitor mon_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .tx_pin);
`default_nettype wire

// ===== dv/ast_line_model.sv
// remote serial node: sends frames on rx and captures frames from tx
`timescale 1ns/10ps
`default_nettype none
module ast_line_model (
    // clock
    input wire logic aclk,
    // serial line
    input wire logic tx_pin,
    output var logic rx_pin
);
    int nbits = 8;
    logic [8:0] got [$];
    logic [8:0] v;
    initial rx_pin = 1'h1;
    // one frame at sixteen clocks a bit; clocks 10 and 11 of bit gl inverted as noise
    // a single-clock flip never gets past the pin filter, two flip only the last sample
    task automatic send(input logic [8:0] d, input int gl, input logic stp);
        logic b;
        for (int i = 0; i <= nbits + 1; i++) begin
            b = (i == 0) ? 1'h0 : (i > nbits) ? stp : d[i-1];
            for (int c = 0; c < 16; c++) begin
                @(posedge aclk);
                rx_pin <= (i == gl && (c == 10 || c == 11)) ? ~b : b;
            end
        end
        @(posedge aclk);
        rx_pin <= 1'h1;
    endtask : send
    // capture at bit centres, keep frames with a good stop bit
    always begin
        @(negedge tx_pin);
        v = '0;
        repeat (8) @(posedge aclk);
        for (int i = 0; i < nbits; i++) begin
            repeat (16) @(posedge aclk);
            v[i] = tx_pin;
        end
        repeat (16) @(posedge aclk);
        if (tx_pin) got.push_back(v);
    end
endmodule : ast_line_model
`default_nettype wire

// ===== dv/ast_top_tb.sv
// self-checking bench for the transceiver top
`timescale 1ns/10ps
`default_nettype none
module ast_top_tb;
    import ast_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_pin, tx_pin;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int fails, comparisons;
    logic [7:0] td [5] = '{8'h55, 8'h55, 8'h81, 8'h0F, 8'h33};
    int tg [5] = '{-1, 4, 0, -1, 9};
    logic [7:0] tf [5] = '{8'h00, 8'h04, 8'h04, 8'h02, 8'h04};
    ast_top #(.FIFO_DEPTH(AST_FIFO_DEPTH)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rx_pin, .tx_pin);
    ast_line_model line_u (.aclk, .tx_pin, .rx_pin);
    // 125 MHz clock
    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // register write: address and data together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rdreg(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : rdreg
    // one received frame: flags, ninth bit, byte, then flags cleared
    task automatic rx_frame(input logic [8:0] d, input int gl, input logic stp,
        input logic [7:0] flags);
        line_u.send(d, gl, stp);
        do begin
            rdreg(AST_OFS_STATUS);
        end while (rd[AST_ST_RX_FULL] !== 1'h1);
        check("status on receive", 32'hE0 | flags, rd);
        rdreg(AST_OFS_DATA_HIGH);
        check("ninth bit", {24'h0, d[8], 7'h0}, rd);
        rdreg(AST_OFS_DATA_LOW);
        check("received byte", {24'h0, d[7:0]}, rd);
        rdreg(AST_OFS_STATUS);
        check("status after data read", 32'hC0, rd);
    endtask : rx_frame
    task automatic end_sim;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    // watchdog well beyond the expected run
    initial begin
        #200000;
        fails++;
        end_sim;
    end
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        aresetn = 1'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rdreg(AST_OFS_STATUS);
        check("status after reset", 32'hC0, rd);
        rdreg(AST_OFS_DIVISOR);
        check("divisor after reset", 32'h4, rd);
        rdreg(8'h20);
        check("unmapped read resp", 32'h2, {30'h0, resp});
        wr(8'h20, 32'hFF);
        check("unmapped write resp", 32'h2, {30'h0, resp});
        wr(AST_OFS_DIVISOR, 32'h1001);
        rdreg(AST_OFS_DIVISOR);
        check("divisor", 32'h1001, rd);
        wr(AST_OFS_DIVISOR, 32'h1);
        wr(AST_OFS_CONTROL, 32'h10);
        line_u.nbits = 9;
        wr(AST_OFS_DATA_HIGH, 32'h40);
        wr(AST_OFS_DATA_LOW, 32'h3C);
        wait (line_u.got.size() == 1);
        check("nine-bit frame", 32'h13C, {23'h0, line_u.got.pop_front()});
        rx_frame(9'h1A7, -1, 1'h1, 8'h00);
        wr(AST_OFS_CONTROL, 32'h0);
        line_u.nbits = 8;
        for (int i = 0; i < 5; i++) rx_frame({1'h0, td[i]}, tg[i], i != 3, tf[i]);
        // second frame lands while the first is unread: overrun, first byte kept
        line_u.send(9'h0AA, -1, 1'h1);
        line_u.send(9'h055, -1, 1'h1);
        repeat (8) @(posedge aclk);
        rdreg(AST_OFS_STATUS);
        check("status on overrun", 32'hE8, rd);
        rdreg(AST_OFS_DATA_LOW);
        check("byte kept on overrun", 32'hAA, rd);
        rdreg(AST_OFS_STATUS);
        check("status after overrun clear", 32'hC0, rd);
        for (int i = 0; i < 17; i++) wr(AST_OFS_DATA_LOW, 32'(i));
        rdreg(AST_OFS_STATUS);
        check("status with fifo full", 32'h0, rd);
        wr(AST_OFS_DATA_LOW, 32'h11);
        wait (line_u.got.size() == 18);
        for (int i = 0; i < 18; i++) check("queued byte", 32'(i), {23'h0, line_u.got[i]});
        repeat (32) @(posedge aclk);
        rdreg(AST_OFS_STATUS);
        check("status when drained", 32'hC0, rd);
        end_sim;
    end
endmodule : ast_top_tb
`default_nettype wire
